// ---- rvs_partner.sv ----
// operator switches and mains supply seen by the sequencer
`timescale 1ns/1ps
module rvs_partner
	import rvs_pkg::*;
#(
	parameter int HALF = 8 // clocks per mains half cycle
)(
	input  wire logic ref_clk,
	input  wire logic init_cl,    // initiate switch closed
	input  wire logic tog_cl,     // toggle switch closed
	input  wire logic aux_cl,     // aux retract switch closed
	input  wire logic est_cl,     // emergency stop pressed
	output logic      initiate_n,
	output logic      toggle_n,
	output logic      aux_ret_n,
	output logic      estop_n,
	output logic      line_sync
);
	logic [7:0] cnt; // clocks within the half cycle

	initial begin
		cnt = 8'h00;
		line_sync = 1'b0;
	end

	// mains wave: one edge per half cycle, so timers see real ticks
	always @(posedge ref_clk) begin
		if (cnt == 8'(HALF - 1)) begin
			cnt <= 8'h00;
			line_sync <= ~line_sync;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end

	// contacts pull to ground, so a closed switch reads low
	assign initiate_n = ~init_cl;
	assign toggle_n   = ~tog_cl;
	assign aux_ret_n  = ~aux_cl;
	assign estop_n    = ~est_cl;
endmodule : rvs_partner

// ---- rvs_pkg.sv ----
// package of constants and types for the retraction valve sequencer
package rvs_pkg;
	// register byte offsets
	localparam logic [7:0] RVS_CFG_OFS  = 8'h00;
	localparam logic [7:0] RVS_TIM0_OFS = 8'h04;
	localparam logic [7:0] RVS_TIM1_OFS = 8'h08;
	localparam logic [7:0] RVS_TIM2_OFS = 8'h0C;
	localparam logic [7:0] RVS_STAT_OFS = 8'h10;
	// function codes
	localparam logic [7:0] RVS_PO_AOO   = 8'h07; // air-over-oil
	localparam logic [7:0] RVS_BS_MAINT = 8'h09; // maintained closure
	// field positions in the config word
	localparam int RVS_CFG_RPT  = 16;
	localparam int RVS_CFG_PREQ = 17;
	localparam int RVS_CFG_CHN  = 18;
	// blink divider bit of the full-cycle counter
	localparam int RVS_BLINK_BIT = 4;
	// AXI responses
	localparam logic [1:0] RVS_OKAY   = 2'h0;
	localparam logic [1:0] RVS_SLVERR = 2'h2;

	// sequence states
	typedef enum logic [3:0] {
		ST_IDLE, ST_SQD, ST_EXT, ST_INT, ST_WELD, ST_HOLD,
		ST_BLKD, ST_OFFR, ST_TADV, ST_TSTOP
	} rvs_state_t;

	// software settings
	typedef struct packed {
		logic [7:0] po_fn;     // process output function
		logic [7:0] bs_fn;     // retraction mode function
		logic       rpt;       // repeat mode
		logic       prog_req;  // request programming mode
		logic       chain;     // chain schedule 01 after 00
		logic [7:0] sqz_dly;   // common squeeze delay, half cycles
		logic [7:0] blk_dly;   // common blocking delay, cycles
		logic [7:0] adv_stop;  // schedule 00 off time, half cycles
		logic [7:0] ext_sqz;   // schedule 00 squeeze
		logic [7:0] int_sqz;   // schedule 01 squeeze
		logic [7:0] weld;      // weld time
		logic [7:0] hold;      // hold time
		logic [7:0] off;       // off time
	} rvs_cfg_t;

	// complete module state
	typedef struct packed {
		logic [2:0]  sy_init, sy_tog, sy_aux, sy_est, sy_line; // synchronisers
		rvs_state_t  st;
		logic [8:0]  tmr;      // sequence timer
		logic [7:0]  bcnt;     // full-cycle counter for blink
		logic        ph;       // dim phase
		logic        armed;    // maintained-mode interlock armed
		rvs_cfg_t    cfg;
		logic        ext_v, int_v, blk_v, ret_v, weld_o;
		logic        led_sqz, led_off, led_po, prog_ok;
		logic        awrdy, bvld, arrdy, rvld;
		logic [1:0]  bresp, rresp;
		logic [31:0] rdata;
	} rvs_reg_t;
endpackage : rvs_pkg

// ---- rvs_top.sv ----
// air-over-oil and maintained-closure retraction valve sequencer
// Functional notes
// - chained schedules still run in maintained mode
// - no programming while retraction valve on
// - retraction lamp does not mirror output
// - retraction valve works outside weld sequence
// - function 07 selects three-valve air-over-oil mode
// - initiation: extend, intensify, weld, hold; without chain, extend goes straight to hold
// - hold end drops valves, starts blocking delay
// - blocking delay expiry turns blocking valve on
// - blocking valve stays on, wait for initiation
// - extend valve on clears blocking valve
// - squeeze delay only from fully retracted
// - toggle advance: extend for squeeze delay
// - advance stop is off time; then blocking
// - advance stop only during toggle advance
// - squeeze delay, advance stop in half cycles
// - blocking on: blink lamp, refuse programming
// - toggle while blocking clears blocking valve; ignored in ST_OFFR
// - emergency stop clears blocking, stays off
// - emergency stop aborts, all valves and weld output off
// - repeat timing against blocking delay
// - delays dim squeeze and off lamps
// - one common delay pair for all schedules
// - blocking delay editable only with 07
// - maintained output follows closed switch
// - power-on interlock on maintained output
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module rvs_top
	import rvs_pkg::*;
(
	input  wire logic        REF_CLK,
	input  wire logic        RESET,
	input  wire logic        INITIATE_N,   // sequence_initiate_input, closed low
	input  wire logic        TOGGLE_N,     // retract_toggle_input, closed low
	input  wire logic        AUX_RET_N,    // aux_retract_switch_input, closed low
	input  wire logic        ESTOP_N,      // emergency stop, active low
	input  wire logic        LINE_SYNC,    // mains square wave
	output logic             EXTEND_VALVE,
	output logic             INTENSIFY_VALVE,
	output logic             BLOCKING_VALVE_OUTPUT,
	output logic             RETRACT_VALVE,
	output logic             WELD_OUT,
	output logic             LED_SQUEEZE,
	output logic             LED_OFF,
	output logic             LED_BLOCKING,
	output logic             PROG_GRANTED,
	input  wire logic [7:0]  AWADDR,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output logic             WREADY,
	output logic [1:0]       BRESP,
	output logic             BVALID,
	input  wire logic        BREADY,
	input  wire logic [7:0]  ARADDR,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	output logic             RVALID,
	input  wire logic        RREADY
);
	rvs_reg_t s_r;   // registered state
	rvs_reg_t s_nxt; // next state

	// decoded helpers; switch and line decodes from synchronised copies
	logic init_c, tog_e, aux_c, est_c;
	logic half_t, full_t, aoo, maint, lock, tmr_z;
	logic wr_go, rd_go;
	logic [31:0] wmask, wv, cfgw, t0, t1, t2, stw;

	always_comb begin
		init_c = ~s_r.sy_init[1];
		aux_c  = ~s_r.sy_aux[1];
		est_c  = ~s_r.sy_est[1];
		tog_e  = ~s_r.sy_tog[1] & s_r.sy_tog[2];     // one closure, one edge
		half_t = s_r.sy_line[1] ^ s_r.sy_line[2];     // each line edge
		full_t = half_t & s_r.sy_line[1];             // rising edge only
		aoo    = (s_r.cfg.po_fn == RVS_PO_AOO);
		maint  = (s_r.cfg.bs_fn == RVS_BS_MAINT);
		lock   = s_r.blk_v | s_r.ret_v;
		tmr_z  = (s_r.tmr == '0);
		wr_go  = s_r.awrdy & AWVALID & WVALID;
		rd_go  = s_r.arrdy & ARVALID;
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{WSTRB[i]}};
		end
		cfgw = {13'h0, s_r.cfg.chain, s_r.cfg.prog_req, s_r.cfg.rpt,
			s_r.cfg.bs_fn, s_r.cfg.po_fn};
		t0 = {8'h0, s_r.cfg.adv_stop, s_r.cfg.blk_dly, s_r.cfg.sqz_dly};
		t1 = {s_r.cfg.hold, s_r.cfg.weld, s_r.cfg.int_sqz, s_r.cfg.ext_sqz};
		t2 = {24'h0, s_r.cfg.off};
		stw = {20'h0, s_r.prog_ok, s_r.weld_o, s_r.ret_v, s_r.blk_v,
			s_r.int_v, s_r.ext_v, 2'h0, s_r.st};
	end

	// next-state logic for sequencer, lamps and register slave
	always_comb begin
		s_nxt = s_r;
		wv    = 32'h0; // merged write word, only used while a write is taken
		// two-flop synchronisers plus a third stage for edges
		s_nxt.sy_init = {s_r.sy_init[1:0], INITIATE_N};
		s_nxt.sy_tog  = {s_r.sy_tog[1:0], TOGGLE_N};
		s_nxt.sy_aux  = {s_r.sy_aux[1:0], AUX_RET_N};
		s_nxt.sy_est  = {s_r.sy_est[1:0], ESTOP_N};
		s_nxt.sy_line = {s_r.sy_line[1:0], LINE_SYNC};
		s_nxt.ph = ~s_r.ph;
		if (full_t) begin
			s_nxt.bcnt = s_r.bcnt + 8'h01;
		end

		// timer: half-cycle resolution only in squeeze delay, toggle advance and advance stop
		if (!tmr_z) begin
			if ((s_r.st == ST_SQD || s_r.st == ST_TSTOP || s_r.st == ST_TADV)
				? half_t : full_t) begin
				s_nxt.tmr = s_r.tmr - 9'h001;
			end
		end

		unique case (s_r.st)
			ST_IDLE: begin
				if (aoo && init_c) begin
					s_nxt.blk_v = 1'b0;
					s_nxt.ext_v = 1'b1;
					if (!s_r.blk_v && s_r.cfg.sqz_dly != 8'h00) begin
						s_nxt.st  = ST_SQD;
						s_nxt.tmr = {1'b0, s_r.cfg.sqz_dly};
					end else begin
						s_nxt.st  = ST_EXT;
						s_nxt.tmr = {1'b0, s_r.cfg.ext_sqz};
					end
				end else if (aoo && tog_e) begin
					if (s_r.blk_v) begin
						s_nxt.blk_v = 1'b0;
					end else begin
						s_nxt.ext_v = 1'b1;
						s_nxt.st    = ST_TADV;
						s_nxt.tmr   = {1'b0, s_r.cfg.sqz_dly};
					end
				end
			end
			ST_SQD: begin
				if (tmr_z) begin
					s_nxt.st  = ST_EXT;
					s_nxt.tmr = {1'b0, s_r.cfg.ext_sqz};
				end
			end
			ST_EXT: begin
				if (tmr_z) begin
					if (s_r.cfg.chain) begin
						s_nxt.int_v = 1'b1;
						s_nxt.st    = ST_INT;
						s_nxt.tmr   = {1'b0, s_r.cfg.int_sqz};
					end else begin
						s_nxt.st  = ST_HOLD;
						s_nxt.tmr = '0;
					end
				end
			end
			ST_INT: begin
				if (tmr_z) begin
					s_nxt.weld_o = 1'b1;
					s_nxt.st     = ST_WELD;
					s_nxt.tmr    = {1'b0, s_r.cfg.weld};
				end
			end
			ST_WELD: begin
				if (tmr_z) begin
					s_nxt.weld_o = 1'b0;
					s_nxt.st     = ST_HOLD;
					s_nxt.tmr    = {1'b0, s_r.cfg.hold};
				end
			end
			ST_HOLD: begin
				if (tmr_z) begin
					s_nxt.ext_v = 1'b0;
					s_nxt.int_v = 1'b0;
					s_nxt.st    = ST_BLKD;
					s_nxt.tmr   = {1'b0, s_r.cfg.blk_dly};
				end
			end
			ST_BLKD: begin
				if (tmr_z) begin
					s_nxt.blk_v = 1'b1;
					if (s_r.cfg.rpt && init_c && s_r.cfg.off > s_r.cfg.blk_dly) begin
						s_nxt.st  = ST_OFFR;
						s_nxt.tmr = {1'b0, s_r.cfg.off - s_r.cfg.blk_dly};
					end else begin
						s_nxt.st = ST_IDLE;
					end
				end
			end
			ST_OFFR: begin
				if (tmr_z) begin
					s_nxt.st = ST_IDLE;                   // repeat from idle
				end
			end
			ST_TADV: begin
				if (tmr_z) begin
					s_nxt.ext_v = 1'b0;
					s_nxt.st    = ST_TSTOP;
					s_nxt.tmr   = {1'b0, s_r.cfg.adv_stop};
				end
			end
			ST_TSTOP: begin
				if (tmr_z) begin
					s_nxt.blk_v = 1'b1;
					s_nxt.st    = ST_IDLE;
				end
			end
		endcase

		// leaving air-over-oil mode drops its valves
		if (!aoo) begin
			s_nxt.st     = ST_IDLE;
			s_nxt.ext_v  = 1'b0;
			s_nxt.int_v  = 1'b0;
			s_nxt.blk_v  = 1'b0;
			s_nxt.weld_o = 1'b0;
		end

		// maintained closure: bypasses the valve relay, so it runs outside a sequence
		if (!aux_c) begin
			s_nxt.armed = 1'b1;
		end
		s_nxt.ret_v = maint & s_r.armed & aux_c;
		if (!maint) begin
			s_nxt.armed = 1'b0;                           // re-arm on each entry
		end

		// emergency stop wins over everything
		if (est_c) begin
			s_nxt.st     = ST_IDLE;
			s_nxt.tmr    = '0;
			s_nxt.ext_v  = 1'b0;
			s_nxt.int_v  = 1'b0;
			s_nxt.blk_v  = 1'b0;
			s_nxt.weld_o = 1'b0;
			s_nxt.ret_v  = 1'b0;
		end

		// lamps: half duty dims, counter bit blinks; lamp never mirrors ret_v
		s_nxt.led_sqz = (s_nxt.st == ST_SQD) ? s_r.ph : (s_nxt.st == ST_EXT);
		s_nxt.led_off = (s_nxt.st == ST_BLKD) ? s_r.ph : (s_nxt.st == ST_OFFR);
		s_nxt.led_po  = s_nxt.blk_v & s_r.bcnt[RVS_BLINK_BIT];
		s_nxt.prog_ok = s_r.cfg.prog_req & ~lock;

		// write channel: address and data taken together, one write at a time
		s_nxt.awrdy = AWVALID & WVALID & ~s_r.awrdy & ~s_r.bvld;
		if (s_r.bvld && BREADY) begin
			s_nxt.bvld = 1'b0;
		end
		if (wr_go) begin
			s_nxt.bvld  = 1'b1;
			s_nxt.bresp = RVS_OKAY;
			unique case (AWADDR)
				RVS_CFG_OFS: begin
					wv = (cfgw & ~wmask) | (WDATA & wmask);
					s_nxt.cfg.po_fn    = wv[7:0];
					s_nxt.cfg.bs_fn    = wv[15:8];   // chaining unaffected
					s_nxt.cfg.rpt      = wv[RVS_CFG_RPT];
					s_nxt.cfg.prog_req = wv[RVS_CFG_PREQ];
					s_nxt.cfg.chain    = wv[RVS_CFG_CHN];
				end
				RVS_TIM0_OFS: begin
					wv = (t0 & ~wmask) | (WDATA & wmask);
					if (!lock) begin
						s_nxt.cfg.sqz_dly  = wv[7:0];
						s_nxt.cfg.adv_stop = wv[23:16];
						if (aoo) begin
							s_nxt.cfg.blk_dly = wv[15:8];
						end
					end else begin
						s_nxt.bresp = RVS_SLVERR;
					end
				end
				RVS_TIM1_OFS: begin
					wv = (t1 & ~wmask) | (WDATA & wmask);
					if (!lock) begin
						s_nxt.cfg.ext_sqz = wv[7:0];
						s_nxt.cfg.int_sqz = wv[15:8];
						s_nxt.cfg.weld    = wv[23:16];
						s_nxt.cfg.hold    = wv[31:24];
					end else begin
						s_nxt.bresp = RVS_SLVERR;
					end
				end
				RVS_TIM2_OFS: begin
					wv = (t2 & ~wmask) | (WDATA & wmask);
					if (!lock) begin
						s_nxt.cfg.off = wv[7:0];
					end else begin
						s_nxt.bresp = RVS_SLVERR;
					end
				end
				default: begin
					s_nxt.bresp = RVS_SLVERR;
				end
			endcase
		end

		// read channel: one read at a time
		s_nxt.arrdy = ARVALID & ~s_r.arrdy & ~s_r.rvld;
		if (s_r.rvld && RREADY) begin
			s_nxt.rvld = 1'b0;
		end
		if (rd_go) begin
			s_nxt.rvld  = 1'b1;
			s_nxt.rresp = RVS_OKAY;
			unique case (ARADDR)
				RVS_CFG_OFS:  s_nxt.rdata = cfgw;
				RVS_TIM0_OFS: s_nxt.rdata = t0;
				RVS_TIM1_OFS: s_nxt.rdata = t1;
				RVS_TIM2_OFS: s_nxt.rdata = t2;
				RVS_STAT_OFS: s_nxt.rdata = stw;
				default: begin
					s_nxt.rdata = 32'h0;
					s_nxt.rresp = RVS_SLVERR;
				end
			endcase
		end
	end

	// state register, synchronous reset; pins idle high
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			s_r         <= '0;
			s_r.sy_init <= 3'h7;
			s_r.sy_tog  <= 3'h7;
			s_r.sy_aux  <= 3'h7;
			s_r.sy_est  <= 3'h7;
			s_r.st      <= ST_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from flops
	assign EXTEND_VALVE          = s_r.ext_v;
	assign INTENSIFY_VALVE       = s_r.int_v;
	assign BLOCKING_VALVE_OUTPUT = s_r.blk_v;
	assign RETRACT_VALVE         = s_r.ret_v;
	assign WELD_OUT              = s_r.weld_o;
	assign LED_SQUEEZE           = s_r.led_sqz;
	assign LED_OFF               = s_r.led_off;
	assign LED_BLOCKING          = s_r.led_po;
	assign PROG_GRANTED          = s_r.prog_ok;
	assign AWREADY               = s_r.awrdy;
	assign WREADY                = s_r.awrdy;
	assign BVALID                = s_r.bvld;
	assign BRESP                 = s_r.bresp;
	assign ARREADY               = s_r.arrdy;
	assign RVALID                = s_r.rvld;
	assign RDATA                 = s_r.rdata;
	assign RRESP                 = s_r.rresp;

	// checks
	chk_estop_all_off: assert property (@(posedge REF_CLK) disable iff (RESET)
		est_c |=> !s_r.ext_v && !s_r.int_v && !s_r.weld_o && !s_r.ret_v)
		else $error("outputs on after emergency stop");
	chk_estop_blk_stays: assert property (@(posedge REF_CLK) disable iff (RESET)
		est_c ##1 !est_c |=> !s_r.blk_v)
		else $error("blocking valve back on after stop release");
	chk_extend_clears_blk: assert property (@(posedge REF_CLK) disable iff (RESET)
		$rose(s_r.ext_v) |-> !s_r.blk_v)
		else $error("extend and blocking on together");
	chk_prog_refused: assert property (@(posedge REF_CLK) disable iff (RESET)
		(s_r.ret_v || s_r.blk_v) |=> !s_r.prog_ok)
		else $error("programming granted while valve on");
	chk_hold_end_drop: assert property (@(posedge REF_CLK) disable iff (RESET)
		(s_r.st == ST_HOLD && tmr_z && !est_c && aoo) |=> s_r.st == ST_BLKD && !s_r.ext_v)
		else $error("hold end did not start blocking delay");
	chk_blk_after_delay: assert property (@(posedge REF_CLK) disable iff (RESET)
		(s_r.st == ST_BLKD && tmr_z && !est_c && aoo) |=> s_r.blk_v)
		else $error("blocking valve not on after delay");
	chk_sqd_skip: assert property (@(posedge REF_CLK) disable iff (RESET)
		(s_r.st == ST_IDLE && s_r.blk_v) |=> s_r.st != ST_SQD)
		else $error("squeeze delay entered with blocking valve on");
	chk_interlock: assert property (@(posedge REF_CLK) disable iff (RESET)
		!s_r.armed |=> !s_r.ret_v)
		else $error("retraction valve on before interlock armed");
	chk_blink_only_blk: assert property (@(posedge REF_CLK) disable iff (RESET)
		s_r.led_po |-> $past(s_nxt.blk_v, 1) || s_r.blk_v)
		else $error("blocking lamp lit with valve off");
endmodule : rvs_top

// ---- tb_top.sv ----
// self-checking bench for the retraction valve sequencer
`timescale 1ns/1ps
module tb_top import rvs_pkg::*;;
	localparam int HALF = 8;      // clocks per half cycle
	localparam int LIMIT = 20000; // hang ceiling in clocks
	localparam int EXT = 0, INT = 1, BLK = 2, RET = 3, PG = 8;
	logic        clk, rst, init_cl, tog_cl, aux_cl, est_cl;
	wire         init_n, tog_n, aux_n, est_n, line_s;
	logic        ext_v, int_v, blk_v, ret_v, weld_o, led_s, led_o, led_p, prog_g;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	int          num_errors, cmp_count, cyc, t0;
	logic        s;
	wire  [8:0]  outs = {prog_g, led_p, led_o, led_s, weld_o, ret_v, blk_v, int_v, ext_v};

	rvs_partner #(.HALF(HALF)) i_rvs_partner (.ref_clk(clk), .init_cl(init_cl),
		.tog_cl(tog_cl), .aux_cl(aux_cl), .est_cl(est_cl), .initiate_n(init_n),
		.toggle_n(tog_n), .aux_ret_n(aux_n), .estop_n(est_n), .line_sync(line_s));

	rvs_top i_rvs_top (.REF_CLK(clk), .RESET(rst), .INITIATE_N(init_n),
		.TOGGLE_N(tog_n), .AUX_RET_N(aux_n), .ESTOP_N(est_n), .LINE_SYNC(line_s),
		.EXTEND_VALVE(ext_v), .INTENSIFY_VALVE(int_v), .BLOCKING_VALVE_OUTPUT(blk_v),
		.RETRACT_VALVE(ret_v), .WELD_OUT(weld_o), .LED_SQUEEZE(led_s), .LED_OFF(led_o),
		.LED_BLOCKING(led_p), .PROG_GRANTED(prog_g), .AWADDR(awaddr), .AWVALID(awvalid),
		.AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
		.BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
		.ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
		.RVALID(rvalid), .RREADY(rready));

	// free-running clock, 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// cycle count doubles as the hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			num_errors++;
			$display("timeout after %0d clocks", cyc);
			tally_and_finish();
		end
	end

	// value compare, counted
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// axi write: address and data offered together, held until taken
	task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do @(posedge clk); while (awready !== 1'b1);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b1;
		do @(posedge clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask : wr

	// axi read; only the masked bits are compared
	task rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk("rdata", e, rdata & m);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask : rd

	// wait, bounded, for an output to reach a level
	task wait_lvl(input int k, input logic v, input int lim);
		int n;
		n = 0;
		while (outs[k] !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk($sformatf("output %0d", k), {31'h0, v}, {31'h0, outs[k]});
	endtask : wait_lvl

	// one short closure of the toggle switch
	task pulse_tog;
		tog_cl <= 1'b1;
		repeat (6) @(posedge clk);
		tog_cl <= 1'b0;
	endtask : pulse_tog

	// elapsed clocks since t0 must lie between three and five half cycles
	task chk_span(input string n);
		chk(n, 32'h1, {31'h0, logic'(cyc - t0 >= 3 * HALF && cyc - t0 <= 5 * HALF)});
	endtask : chk_span

	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	initial begin
		{rst, init_cl, tog_cl, aux_cl, est_cl} = 5'h10;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata} = 48'h0;
		{num_errors, cmp_count, cyc, t0} = '0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// reset values and an unmapped place
		rd(RVS_CFG_OFS, 32'hFFFFFFFF, 32'h0, RVS_OKAY);
		rd(8'h14, 32'hFFFFFFFF, 32'h0, RVS_SLVERR);
		// blocking delay is locked until air-over-oil is chosen
		wr(RVS_TIM0_OFS, 32'h00040204, RVS_OKAY);
		rd(RVS_TIM0_OFS, 32'h0000FF00, 32'h0, RVS_OKAY);
		wr(RVS_CFG_OFS, 32'h00060007, RVS_OKAY);
		wr(RVS_TIM0_OFS, 32'h00040204, RVS_OKAY);
		rd(RVS_TIM0_OFS, 32'h00FFFFFF, 32'h00040204, RVS_OKAY);
		wr(RVS_TIM1_OFS, 32'h02020203, RVS_OKAY);
		wr(RVS_TIM2_OFS, 32'h0, RVS_OKAY);
		$display("test registers done");
		// full sequence from the fully retracted state
		init_cl <= 1'b1;
		wait_lvl(EXT, 1'b1, 50);
		rd(RVS_STAT_OFS, 32'hF, {28'h0, ST_SQD}, RVS_OKAY);
		s = led_s;
		@(posedge clk);
		chk("squeeze lamp dim", 32'h1, {31'h0, s ^ led_s});
		wait_lvl(INT, 1'b1, 200);
		wait_lvl(4, 1'b1, 200);
		// open the switch before the end, a held switch would start again
		init_cl <= 1'b0;
		wait_lvl(EXT, 1'b0, 200);
		s = led_o;
		@(posedge clk);
		chk("off lamp dim", 32'h1, {31'h0, s ^ led_o});
		wait_lvl(BLK, 1'b1, 300);
		chk("valves after hold", 32'h0, {30'h0, ext_v, int_v});
		repeat (300) @(posedge clk);
		chk("blocking kept", 32'h1, {31'h0, blk_v});
		rd(RVS_STAT_OFS, 32'hF, {28'h0, ST_IDLE}, RVS_OKAY);
		wait_lvl(7, ~led_p, 600);
		wr(RVS_TIM1_OFS, 32'h0, RVS_SLVERR);
		chk("prog granted", 32'h0, {31'h0, prog_g});
		$display("test sequence done");
		// initiation with blocking on, then stopped in mid-sequence
		init_cl <= 1'b1;
		wait_lvl(EXT, 1'b1, 50);
		chk("blocking on extend", 32'h0, {31'h0, blk_v});
		rd(RVS_STAT_OFS, 32'hF, {28'h0, ST_EXT}, RVS_OKAY);
		wait_lvl(INT, 1'b1, 200);
		est_cl <= 1'b1;
		repeat (5) @(posedge clk);
		chk("outputs on stop", 32'h0, {27'h0, outs[4:0]});
		est_cl <= 1'b0;
		init_cl <= 1'b0;
		wait_lvl(PG, 1'b1, 20);
		$display("test stop done");
		// toggle advance, advance stop, then toggle back
		pulse_tog();
		wait_lvl(EXT, 1'b1, 20);
		t0 = cyc;
		wait_lvl(EXT, 1'b0, 100);
		chk_span("advance span");
		t0 = cyc;
		wait_lvl(BLK, 1'b1, 100);
		chk_span("advance stop span");
		pulse_tog();
		wait_lvl(BLK, 1'b0, 20);
		repeat (100) @(posedge clk);
		chk("one change per closure", 32'h0, {31'h0, blk_v});
		pulse_tog();
		wait_lvl(BLK, 1'b1, 150);
		est_cl <= 1'b1;
		wait_lvl(BLK, 1'b0, 10);
		est_cl <= 1'b0;
		repeat (200) @(posedge clk);
		chk("blocking after stop", 32'h0, {31'h0, blk_v});
		$display("test toggle done");
		// repeat: off above blocking delay runs the rest, otherwise repeat at once
		wr(RVS_TIM2_OFS, 32'h00000005, RVS_OKAY);
		wr(RVS_CFG_OFS, 32'h00070007, RVS_OKAY);
		init_cl <= 1'b1;
		wait_lvl(BLK, 1'b1, 400);
		t0 = cyc;
		rd(RVS_STAT_OFS, 32'hF, {28'h0, ST_OFFR}, RVS_OKAY);
		chk("off lamp steady", 32'h1, {31'h0, led_o});
		wait_lvl(EXT, 1'b1, 100);
		chk("repeat off span", 32'h1,
			{31'h0, logic'(cyc - t0 > 4 * HALF && cyc - t0 <= 7 * HALF)});
		wr(RVS_TIM2_OFS, 32'h00000001, RVS_OKAY);
		wait_lvl(BLK, 1'b1, 400);
		t0 = cyc;
		wait_lvl(EXT, 1'b1, 10);
		chk("repeat at once", 32'h1, {31'h0, logic'(cyc - t0 <= 2)});
		init_cl <= 1'b0;
		wait_lvl(BLK, 1'b1, 400);
		$display("test repeat done");
		// maintained closure with switch already closed
		aux_cl <= 1'b1;
		wr(RVS_CFG_OFS, 32'h00020900, RVS_OKAY);
		repeat (20) @(posedge clk);
		chk("retract at arm", 32'h0, {31'h0, ret_v});
		aux_cl <= 1'b0;
		repeat (5) @(posedge clk);
		aux_cl <= 1'b1;
		wait_lvl(RET, 1'b1, 10);
		// the grant flop follows the valve one clock later
		@(posedge clk);
		chk("prog while retract", 32'h0, {31'h0, prog_g});
		chk("lamp ignores retract", 32'h0, {31'h0, led_p});
		wr(RVS_TIM0_OFS, 32'h0, RVS_SLVERR);
		aux_cl <= 1'b0;
		wait_lvl(RET, 1'b0, 10);
		$display("test maintained done");
		tally_and_finish();
	end
endmodule : tb_top
